// [sfsr_map.vh]
// Constants for the serial flash status register block
`ifndef SFSR_MAP_VH
`define SFSR_MAP_VH

// Opcodes handled inside this block
`define SFSR_OPC_RD_STATUS 8'h05
`define SFSR_OPC_WR_STATUS 8'h01

// Status byte field positions
`define SFSR_BIT_LOCK 7
`define SFSR_BIT_SEQ 6
`define SFSR_BIT_FAIL 5
`define SFSR_BIT_PIN 4
`define SFSR_BIT_SWP_HI 3
`define SFSR_BIT_SWP_LO 2
`define SFSR_BIT_WEL 1
`define SFSR_BIT_BUSY 0

// Reset values of the status fields
`define SFSR_RST_LOCK 1'b0
`define SFSR_RST_SEQ 1'b0
`define SFSR_RST_FAIL 1'b0
`define SFSR_RST_SWP 2'b11
`define SFSR_RST_WEL 1'b0
`define SFSR_RST_BUSY 1'b0

// Bit counts of a frame
`define SFSR_OPC_LAST 5'd7
`define SFSR_DATA_LAST 5'd15
`define SFSR_FRAME_BITS 5'd16
`define SFSR_BYTE_LAST 3'd7

`endif

// [sfsr_status.v]
// Status register logic of a serial flash behind an SPI slave port
// What this block does
// (R1) Chip select low plus opcode 05h starts status bits on the data out.
// (R2) After bit 0 the byte repeats from bit 7 while clocking continues.
// (R3) Every repeated byte is a fresh snapshot of the live flags.
// (R4) Status read is accepted at any time, even while busy.
// (R5) Chip select high ends the read and floats the data out at once.
// (R6) Lock set refuses protect, unprotect and global protect changes.
// (R7) Lock flag clears on reset.
// (R8) With guard pin asserted the lock may only go from 0 to 1.
// (R9) Status write stores only bit 7; other bits show internal state.
// (R10) Bit 6 shows sequential program mode; reset gives byte/page mode.
// (R11) Bit 5 is updated after each erase or program: 1 on failure.
// (R12) An aborted erase or program leaves the error flag alone.
// (R13) Bit 4 reads 0 with the guard pin asserted, 1 when released.
// (R14) Bits 3:2 summarise sector protection, all protected by default.
// (R15) Write enable latch clear rejects all modifying commands.
// (R16) Write enable latch clears on reset.
// (R17) Latch clears when write disable, status write or any op ends.
// (R18) Sequential programming end or abort clears the latch.
// (R19) A partial or unknown opcode never clears a set latch.
// (R20) Bit 0 reads 1 while a self-timed operation runs.
// (R21) The host polls status bytes until bit 0 falls.
// (R22) Status write is 01h then one byte, needs the latch set first.
// (R23) Bits are taken on rising clock, sent MSB first on falling clock.
`timescale 1ns/1ps
`include "sfsr_map.vh"

module sfsr_status #(
    parameter [7:0] OPC_WR_EN = 8'h06,
    parameter [7:0] OPC_WR_DIS = 8'h04,
    parameter [7:0] OPC_PROT = 8'h36,
    parameter [7:0] OPC_UNPROT = 8'h39
) (
    // Clock and reset
    input wire mclk_i,
    input wire srst_i,
    // SPI pins
    input wire cs_n_i,
    input wire sck_i,
    input wire si_i,
    output reg so_o,
    output reg so_oe_o,
    // Guard pin, active low
    input wire guard_n_i,
    // State from the program and erase engine
    input wire op_in_progress_i,
    input wire sequential_prog_i,
    input wire [1:0] soft_protect_i,
    input wire op_end_i,
    input wire op_abort_i,
    input wire op_fail_i,
    input wire hold_abort_i,
    // Opcodes handed to the engine
    output reg fwd_vld_o,
    output reg [7:0] fwd_code_o,
    output reg fwd_ok_o,
    // Global protect request
    output reg glob_vld_o,
    output reg [3:0] glob_bits_o,
    // Flag levels for the engine
    output reg lock_o,
    output reg wel_o
);

    // Synchroniser stages
    reg cs_s1_q;
    reg cs_s2_q;
    reg cs_s3_q;
    reg sck_s1_q;
    reg sck_s2_q;
    reg sck_s3_q;
    reg si_s1_q;
    reg si_s2_q;
    reg wp_s1_q;
    reg wp_s2_q;

    // Receive side
    reg [4:0] bcnt_q;
    reg [7:0] rx_q;
    reg [7:0] opc_q;
    reg opc_evt_q;
    reg [7:0] wdat_q;
    reg wfull_q;
    reg wpend_q;

    // Transmit side
    reg rd_q;
    reg [2:0] tcnt_q;
    reg [7:0] tx_q;
    reg first_q;

    // Status flags
    reg lock_q;
    reg seq_q;
    reg fail_q;
    reg pin_q;
    reg [1:0] swp_q;
    reg wel_q;
    reg busy_q;

    wire cs_on;
    wire sck_rise;
    wire sck_fall;
    wire cs_end;
    wire [7:0] live;
    wire [7:0] rx_next;
    wire is_prot;
    wire wel_set;
    wire wel_clr;
    reg wel_d;

    // Two flip-flops on every pin before use
    // Pins are asynchronous to the system clock, so every pin passes two
    // flip-flops first; the third clock and select stages only feed the
    // edge detectors and never see a raw pin level.
    // Reset values match idle pins, so no false edge follows reset.
    always @(posedge mclk_i) begin
        if (srst_i) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_s3_q <= 1'b0;
            si_s1_q <= 1'b0;
            si_s2_q <= 1'b0;
            wp_s1_q <= 1'b1;
            wp_s2_q <= 1'b1;
        end else begin
            cs_s1_q <= cs_n_i;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            sck_s1_q <= sck_i;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            si_s1_q <= si_i;
            si_s2_q <= si_s1_q;
            wp_s1_q <= guard_n_i;
            wp_s2_q <= wp_s1_q;
        end
    end

    // Frame and clock edge detection
    assign cs_on = ~cs_s2_q;
    assign sck_rise = sck_s2_q & ~sck_s3_q; // R23
    assign sck_fall = ~sck_s2_q & sck_s3_q; // R23
    assign cs_end = cs_s2_q & ~cs_s3_q;
    assign rx_next = {rx_q[6:0], si_s2_q};

    // Live status byte as seen now
    assign live = {lock_q, seq_q, fail_q, pin_q, swp_q, wel_q, busy_q}; // R9

    // Receive shifter: opcode then one data byte, extra bits ignored
    always @(posedge mclk_i) begin
        if (srst_i) begin
            bcnt_q <= 5'd0;
            rx_q <= 8'h00;
            opc_q <= 8'h00;
            opc_evt_q <= 1'b0;
            wdat_q <= 8'h00;
            wfull_q <= 1'b0;
        end else begin
            opc_evt_q <= 1'b0;
            if (!cs_on) begin
                bcnt_q <= 5'd0;
            end else if (sck_rise && bcnt_q != `SFSR_FRAME_BITS) begin
                rx_q <= rx_next;
                bcnt_q <= bcnt_q + 5'd1;
                if (bcnt_q == `SFSR_OPC_LAST) begin
                    opc_q <= rx_next; // R1
                    opc_evt_q <= 1'b1;
                end
                if (bcnt_q == `SFSR_DATA_LAST) begin
                    wdat_q <= rx_next; // R22
                    wfull_q <= 1'b1;
                end
            end
            if (cs_end) begin
                wfull_q <= 1'b0;
            end
        end
    end

    // Protect and unprotect opcodes are refused while locked
    assign is_prot = (opc_q == OPC_PROT) || (opc_q == OPC_UNPROT);

    // Hand complete opcodes not handled here to the engine
    always @(posedge mclk_i) begin
        if (srst_i) begin
            fwd_vld_o <= 1'b0;
            fwd_code_o <= 8'h00;
            fwd_ok_o <= 1'b0;
        end else begin
            fwd_vld_o <= 1'b0;
            if (opc_evt_q && opc_q != `SFSR_OPC_RD_STATUS &&
                opc_q != `SFSR_OPC_WR_STATUS && opc_q != OPC_WR_EN &&
                opc_q != OPC_WR_DIS) begin
                fwd_vld_o <= 1'b1;
                fwd_code_o <= opc_q;
                fwd_ok_o <= wel_q & ~(lock_q & is_prot); // R15 R6
            end
        end
    end

    // Status read transmitter, no busy gating
    // The first falling edge after the opcode, and every eighth one after
    // it, takes a new snapshot of the live flags, so a host that keeps
    // clocking sees busy and the other flags change during the read.
    // Chip select high at any bit drops the enable without waiting for
    // a byte boundary.
    always @(posedge mclk_i) begin
        if (srst_i) begin
            rd_q <= 1'b0;
            tcnt_q <= 3'd0;
            tx_q <= 8'h00;
            first_q <= 1'b0;
            so_o <= 1'b0;
            so_oe_o <= 1'b0;
        end else if (!cs_on) begin
            rd_q <= 1'b0; // R5
            tcnt_q <= 3'd0;
            first_q <= 1'b0;
            so_oe_o <= 1'b0; // R5
        end else begin
            if (opc_evt_q && opc_q == `SFSR_OPC_RD_STATUS) begin
                rd_q <= 1'b1; // R1 R4
                first_q <= 1'b1;
            end
            if (sck_fall && rd_q) begin
                so_oe_o <= 1'b1;
                first_q <= 1'b0;
                if (first_q || tcnt_q == 3'd0) begin
                    so_o <= live[7]; // R2 R3
                    tx_q <= {live[6:0], 1'b0}; // R3
                    tcnt_q <= `SFSR_BYTE_LAST;
                end else begin
                    so_o <= tx_q[7]; // R23
                    tx_q <= {tx_q[6:0], 1'b0};
                    tcnt_q <= tcnt_q - 3'd1; // R2
                end
            end
        end
    end

    // Pending status write needs the whole opcode
    always @(posedge mclk_i) begin
        if (srst_i) begin
            wpend_q <= 1'b0;
        end else if (cs_end) begin
            wpend_q <= 1'b0;
        end else if (opc_evt_q && opc_q == `SFSR_OPC_WR_STATUS) begin
            wpend_q <= 1'b1; // R19 R22
        end
    end

    // Lock flag and global protect request
    // The status write acts only when chip select rises after a full
    // data byte; a cut byte changes nothing here but still clears the
    // write enable latch below.
    // Clearing the lock is refused while the guard pin is asserted.
    always @(posedge mclk_i) begin
        if (srst_i) begin
            lock_q <= `SFSR_RST_LOCK; // R7
            glob_vld_o <= 1'b0;
            glob_bits_o <= 4'h0;
        end else begin
            glob_vld_o <= 1'b0;
            if (cs_end && wpend_q && wfull_q && wel_q) begin // R15
                if (!(~wp_s2_q && lock_q && !wdat_q[7])) begin // R8
                    lock_q <= wdat_q[7]; // R9
                    if (!lock_q) begin // R6
                        glob_vld_o <= 1'b1;
                        glob_bits_o <= wdat_q[5:2];
                    end
                end
            end
        end
    end

    // Write enable latch events; a set beats a clear in one cycle
    // An engine clear can meet a write enable opcode in one cycle; the
    // set wins so that a write enable from the host is never lost.
    assign wel_set = opc_evt_q && opc_q == OPC_WR_EN;
    assign wel_clr = (opc_evt_q && opc_q == OPC_WR_DIS) || // R17
                     (cs_end && wpend_q) || // R17 R19
                     (opc_evt_q && is_prot && lock_q) || // R6
                     op_end_i || // R17 R18
                     hold_abort_i; // R17

    // Next latch value
    always @* begin
        wel_d = wel_q;
        if (wel_set) begin
            wel_d = 1'b1;
        end else if (wel_clr) begin
            wel_d = 1'b0;
        end
    end

    // Write enable latch register
    always @(posedge mclk_i) begin
        if (srst_i) begin
            wel_q <= `SFSR_RST_WEL; // R16
        end else begin
            wel_q <= wel_d;
        end
    end

    // Error flag updated on completed operations only
    always @(posedge mclk_i) begin
        if (srst_i) begin
            fail_q <= `SFSR_RST_FAIL;
        end else if (op_end_i && !op_abort_i) begin
            fail_q <= op_fail_i; // R11 R12
        end
    end

    // Flags mirrored from the engine and the guard pin
    always @(posedge mclk_i) begin
        if (srst_i) begin
            seq_q <= `SFSR_RST_SEQ; // R10
            pin_q <= 1'b1;
            swp_q <= `SFSR_RST_SWP; // R14
            busy_q <= `SFSR_RST_BUSY;
        end else begin
            seq_q <= sequential_prog_i; // R10
            pin_q <= wp_s2_q; // R13
            swp_q <= soft_protect_i; // R14
            busy_q <= op_in_progress_i; // R20
        end
    end

    // Flag levels for the engine
    always @(posedge mclk_i) begin
        if (srst_i) begin
            lock_o <= `SFSR_RST_LOCK;
            wel_o <= `SFSR_RST_WEL;
        end else begin
            lock_o <= lock_q;
            wel_o <= wel_q;
        end
    end

endmodule // sfsr_status

// [sfsr_status_properties.sv]
// Concurrent checks on the status block ports
`timescale 1ns/1ps
module sfsr_status_properties (
    // Watched ports
    input wire mclk_i, input wire srst_i, input wire cs_n_i,
    input wire so_oe_o, input wire guard_n_i, input wire op_end_i,
    input wire hold_abort_i, input wire fwd_vld_o,
    input wire [7:0] fwd_code_o, input wire fwd_ok_o,
    input wire glob_vld_o, input wire lock_o, input wire wel_o
);
    // Protect or unprotect code on the forward port
    wire prot = fwd_code_o == 8'h36 || fwd_code_o == 8'h39;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    AST_OE_OFF: assert property (cs_n_i [*4] |-> !so_oe_o)
        else $error("data out driven while idle");
    AST_OE_ON: assert property ($rose(so_oe_o)
        |-> !$past(cs_n_i, 60)) else $error("data out before opcode end");
    AST_RST: assert property ($fell(srst_i)
        |-> !wel_o && !lock_o) else $error("flags kept over reset");
    AST_END: assert property (cs_n_i [*4] ##0 op_end_i
        |-> ##2 !wel_o) else $error("latch kept after op end");
    AST_HOLD: assert property (cs_n_i [*4] ##0 hold_abort_i
        |-> ##2 !wel_o) else $error("latch kept after hold abort");
    AST_GUARD: assert property ((!guard_n_i) [*4] ##0 lock_o
        |=> lock_o) else $error("lock cleared with guard asserted");
    AST_LOCKED: assert property (fwd_vld_o && lock_o && prot
        |-> !fwd_ok_o) else $error("protect passed while locked");
    AST_NO_WEL: assert property (fwd_vld_o && fwd_ok_o
        |-> wel_o) else $error("request passed without write enable");
    AST_GLOB: assert property (glob_vld_o
        |-> !$past(lock_o, 4)) else $error("global request while locked");
    cover property (glob_vld_o);
    cover property ($rose(so_oe_o));
    cover property (fwd_vld_o && !fwd_ok_o);
endmodule // sfsr_status_properties
bind sfsr_status sfsr_status_properties i_prop (.mclk_i(mclk_i),
    .srst_i(srst_i), .cs_n_i(cs_n_i), .so_oe_o(so_oe_o),
    .guard_n_i(guard_n_i), .op_end_i(op_end_i), .hold_abort_i(hold_abort_i),
    .fwd_vld_o(fwd_vld_o), .fwd_code_o(fwd_code_o), .fwd_ok_o(fwd_ok_o),
    .glob_vld_o(glob_vld_o), .lock_o(lock_o), .wel_o(wel_o));

// [sfsr_host.sv]
// Host SPI master model that frames commands for the status block
`timescale 1ns/1ps
module sfsr_host (
    // Clock and returned data
    input wire mclk_i, input wire so_i, input wire so_oe_i,
    // Pins driven by the host, clock idle low
    output logic cs_n_o = 1'b1, output logic sck_o = 1'b0,
    output logic si_o = 1'b0
);
    logic last_bit = 1'b0;
    // Wait whole clocks, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // Mode 0 frame: n bits MSB first, half period of 4 clocks
    task automatic xfer(input logic [31:0] tx, input int n,
        output logic [31:0] rx);
        rx = '0;
        cs_n_o = 1'b0;
        tick(4);
        for (int i = 0; i < n; i++) begin
            si_o = tx[31-i];
            tick(4);
            sck_o = 1'b1;
            // A floating data out reads as the inverse of the last bit
            last_bit = so_oe_i ? so_i : ~last_bit;
            rx = {rx[30:0], last_bit};
            tick(4);
            sck_o = 1'b0;
        end
        tick(4);
        cs_n_o = 1'b1;
        si_o = ~si_o;
        tick(6);
    endtask
endmodule // sfsr_host

// [sfsr_status_bench.sv]
// Self-checking bench of the status register block
`timescale 1ns/1ps
module sfsr_status_bench;
    logic mclk_i = 1'b0, srst_i = 1'b1, guard_n = 1'b1, busy = 1'b0;
    logic seq = 1'b0, op_end = 1'b0, abt = 1'b0, fail = 1'b0, hold = 1'b0;
    logic lk = 1'b0, we = 1'b0, fl = 1'b0, ok_q = 1'b0;
    logic [1:0] soft_protect_summary = 2'b11;
    logic cs_n, sck, si, so, so_oe, fwd_vld, fwd_ok, glob_vld, lock, write_enable_latch;
    logic [7:0] fwd_code;
    logic [3:0] glob_bits;
    logic [31:0] rx;
    int n_mismatch = 0, checks = 0, n_glob = 0;
    // Clock of 100 ns
    always #50 mclk_i = ~mclk_i;
    // Count global requests, keep the last forward verdict
    always @(posedge mclk_i) begin
        n_glob <= n_glob + (glob_vld === 1'b1);
        ok_q <= (fwd_vld === 1'b1) ? fwd_ok : ok_q;
    end
    sfsr_status i_dut (.mclk_i(mclk_i), .srst_i(srst_i), .cs_n_i(cs_n),
        .sck_i(sck), .si_i(si), .so_o(so), .so_oe_o(so_oe),
        .guard_n_i(guard_n), .op_in_progress_i(busy),
        .sequential_prog_i(seq), .soft_protect_i(soft_protect_summary), .op_end_i(op_end),
        .op_abort_i(abt), .op_fail_i(fail), .hold_abort_i(hold),
        .fwd_vld_o(fwd_vld), .fwd_code_o(fwd_code), .fwd_ok_o(fwd_ok),
        .glob_vld_o(glob_vld), .glob_bits_o(glob_bits), .lock_o(lock),
        .wel_o(write_enable_latch));
    sfsr_host i_host (.mclk_i(mclk_i), .so_i(so), .so_oe_i(so_oe),
        .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
    // Compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Send a frame of n bits
    task automatic cmd(input logic [31:0] tx, input int n);
        i_host.xfer(tx, n, rx);
    endtask
    // Read one status byte and compare it with the expected flags
    task automatic chk_st();
        cmd(32'h05000000, 16);
        chk(32'(rx[7:0]), {24'h0, lk, seq, fl, guard_n, soft_protect_summary, we, busy});
    endtask
    // One-cycle pulse on the engine ports
    task automatic pulse(input logic a, input logic f, input logic h);
        abt = a;
        fail = f;
        op_end = !h;
        hold = h;
        i_host.tick(1);
        op_end = 1'b0;
        hold = 1'b0;
        i_host.tick(3);
    endtask
    task automatic print_verdict();
        $display("checks %0d, n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Cut a hang short
    initial begin
        i_host.tick(20000);
        n_mismatch++;
        print_verdict();
    end
    // Main sequence
    initial begin
        i_host.tick(20);
        srst_i = 1'b0;
        i_host.tick(4);
        chk_st();
        seq = 1'b1;
        soft_protect_summary = 2'b01;
        fork
            cmd(32'h05000000, 24);
            begin
                i_host.tick(100);
                busy = 1'b1;
            end
        join
        chk(32'(rx[15:0]), 32'h005455);
        busy = 1'b0;
        chk_st();
        cmd(32'h05000000, 12);
        chk(32'(so_oe), 32'h0);
        cmd(32'h06000000, 8);
        we = 1'b1;
        chk_st();
        cmd(32'h01f00000, 16);
        lk = 1'b1;
        we = 1'b0;
        chk_st();
        chk({n_glob[27:0], glob_bits}, 32'h1c);
        guard_n = 1'b0;
        cmd(32'h06000000, 8);
        cmd(32'h01000000, 16);
        we = 1'b0;
        chk_st();
        cmd(32'h06000000, 8);
        cmd(32'h36000000, 32);
        chk(32'({ok_q, fwd_code}), 32'h036);
        guard_n = 1'b1;
        cmd(32'h06000000, 8);
        cmd(32'h010f0000, 16);
        lk = 1'b0;
        chk_st();
        cmd(32'h02000000, 32);
        chk(32'({ok_q, fwd_code}), 32'h002);
        cmd(32'h06000000, 8);
        cmd(32'h02000000, 32);
        chk(32'({ok_q, fwd_code}), 32'h102);
        for (int i = 0; i < 3; i++) begin
            pulse(i == 0, i < 2, 1'b0);
            fl = (i == 1);
            chk_st();
        end
        cmd(32'h06000000, 8);
        cmd(32'h04000000, 7);
        we = 1'b1;
        chk_st();
        pulse(1'b0, 1'b0, 1'b1);
        we = 1'b0;
        chk_st();
        chk(32'(n_glob), 32'h1);
        seq = 1'b0;
        soft_protect_summary = 2'b00;
        cmd(32'h06000000, 8);
        cmd(32'h01800000, 16);
        lk = 1'b1;
        chk_st();
        cmd(32'h06000000, 8);
        // Reset in mid-run with the lock and the latch both set
        srst_i = 1'b1;
        i_host.tick(2);
        srst_i = 1'b0;
        i_host.tick(4);
        lk = 1'b0;
        we = 1'b0;
        chk_st();
        chk({n_glob[27:0], glob_bits}, 32'h20);
        print_verdict();
    end
endmodule // sfsr_status_bench
